// ===== hw/diag_bank_pkg.sv
// constants, types and register map of the motor fault diagnostic bank
// What this block does
// - no back-emf over whole open-loop startup time sets locked rotor flag, drivers off
// - fet drain-source above threshold sets fet short flag, masked during blanking time
// - gate low supply undervoltage sets its flag and disables drivers
// - charge pump low voltage sets its flag and disables drivers
// - main supply overvoltage sets flag, disables drivers and charge pump
// - main supply undervoltage sets flag and disables drivers
// - overcurrent flagged only after sense stays high beyond mask time, drivers off
// - pwm input fault flagged; drivers off or emergency duty per configuration
// - regulator undervoltage threshold chosen by regulator voltage selection
// - checksum error set only when enabled, diag and protect on, and mismatch seen
// - checksum protect mode turns drivers off on checksum error
// - writing 55h to reset command register clears checksum error flag
// - watchdog flag on missed service; drivers off or emergency per action select
// - watchdog flag asserted even when watchdog function is disabled
// - thermal shutdown at level chosen by temperature select, drivers off
// - thermal warning at level chosen by the same temperature select
// - separate bits report raw nvm output all zero and loaded registers all zero
// - speed control error bit set when speed error exceeds target over sixteen
// - startup period bit high during open loop until first back-emf
// - speed fault flag set when speed error seen under accel/decel conditions
// - status bytes show the quantity picked by status select
// - reading low status byte snapshots mid and high bytes
// - mid and high status bytes read zero before any low byte read
// - checksum enable loaded from nvm gates the whole checksum diagnostic
package diag_bank_pkg;

  // ==========================================
  // register map
  localparam logic [11:0] ADDR_FLAGS_A = 12'h201;
  localparam logic [11:0] ADDR_FLAGS_B = 12'h202;
  localparam logic [11:0] ADDR_FLAGS_C = 12'h203;
  localparam logic [11:0] ADDR_FLAGS_D = 12'h204;
  localparam logic [11:0] ADDR_STAT_LOW = 12'h205;
  localparam logic [11:0] ADDR_STAT_MID = 12'h206;
  localparam logic [11:0] ADDR_STAT_HIGH = 12'h207;
  localparam logic [11:0] ADDR_SEED = 12'h208;
  localparam logic [11:0] ADDR_RESET_CMD = 12'h300;
  localparam logic [11:0] ADDR_STAT_SEL = 12'h306;

  // ==========================================
  // command codes and reset values
  localparam logic [7:0] CMD_CLR_WDOG = 8'h00;
  localparam logic [7:0] CMD_CLR_CSUM = 8'h55;
  localparam logic [7:0] CMD_CLR_LATCH = 8'hFF;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_STAT_SEL = 4'h0;
  localparam logic [15:0] RST_STAT_HOLD = 16'h0000;
  localparam int SPEED_ERR_SHIFT = 4;

  // ==========================================
  // timing: ticks of the protection time base
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_US = 1;
  localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;

  // ==========================================
  // analog comparator outputs, each a level
  typedef struct packed {
    logic fet_short_raw;
    logic fet_thermal;
    logic gate_low_uv;
    logic pump_low;
    logic main_ov;
    logic main_uv;
    logic oc_raw;
    logic reg_uv_5v;
    logic reg_uv_3v3;
    logic open_conn;
    logic cur_limit;
    logic temp_shut_lo;
    logic temp_shut_hi;
    logic temp_warn_lo;
    logic temp_warn_hi;
    logic high_supply_ov;
    logic pump_ov;
    logic reverse_cur;
  } sense_type;

  // configuration loaded from registers and nvm
  typedef struct packed {
    logic device_en;
    logic [7:0] open_loop_startup_time;
    logic [7:0] fet_short_blanking;
    logic [7:0] overcurrent_mask_time;
    logic pwm_fault_action_sel;
    logic regulator_voltage_sel;
    logic watchdog_en;
    logic watchdog_action_sel;
    logic temperature_level_sel;
    logic checksum_diag_enable;
    logic checksum_protect_enable;
    logic checksum_protect_mode;
    logic [7:0] checksum_seed_value;
  } config_type;

  // driver stage commands
  typedef struct packed {
    logic drivers_off;
    logic pump_off;
    logic emergency_duty;
  } drive_type;

endpackage

// ===== hw/motor_fault_diag_status_bank.sv
// diagnostic flag and status window register bank of the motor controller
`timescale 1ns/10ps
`default_nettype none
module motor_fault_diag_status_bank
  import diag_bank_pkg::*;
#(
  parameter int SPEED_W = 16
) (
  // clock, reset, enable
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  // register port
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // protection inputs
  input wire sense_type sense_i,
  input wire config_type cfg_i,
  input wire logic bemf_seen_i,
  input wire logic startup_active_i,
  input wire logic pwm_fault_i,
  input wire logic watchdog_expired_i,
  input wire logic checksum_mismatch_i,
  input wire logic nvm_all_zero_i,
  input wire logic loaded_all_zero_i,
  input wire logic [SPEED_W-1:0] speed_target_i,
  input wire logic [SPEED_W-1:0] speed_actual_i,
  input wire logic speed_fault_cond_i,
  // status sources, one 24-bit word per selection
  input wire logic [15:0][23:0] status_src_i,
  // driver stage
  output drive_type drive_o
);

  // ==========================================
  // helpers
  function automatic logic [SPEED_W-1:0] abs_diff(input logic [SPEED_W-1:0] a, input logic [SPEED_W-1:0] b);
    abs_diff = (a > b) ? a - b : b - a;
  endfunction

  function automatic logic count_done(input logic [7:0] cnt, input logic [7:0] limit);
    count_done = (cnt >= limit);
  endfunction

  // ==========================================
  // protection time base
  logic [7:0] tick_cnt_r;
  logic tick_r;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      tick_cnt_r <= 8'h00;
      tick_r <= 1'b0;
    end else if (clk_en_i) begin
      tick_r <= (tick_cnt_r == 8'(TICK_CYCLES - 1));
      if (tick_cnt_r == 8'(TICK_CYCLES - 1)) begin
        tick_cnt_r <= 8'h00;
      end else begin
        tick_cnt_r <= tick_cnt_r + 8'h01;
      end
    end
  end

  // ==========================================
  // locked rotor: whole startup interval without back-emf
  logic [7:0] startup_cnt_r;
  logic locked_rotor_flag_r;
  logic startup_period_bit_r;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      startup_cnt_r <= 8'h00;
      locked_rotor_flag_r <= 1'b0;
    end else if (clk_en_i) begin
      if (!startup_active_i || bemf_seen_i) begin
        startup_cnt_r <= 8'h00;
      end else if (tick_r && !count_done(startup_cnt_r, cfg_i.open_loop_startup_time)) begin
        startup_cnt_r <= startup_cnt_r + 8'h01;
      end
      if (startup_active_i && !bemf_seen_i && count_done(startup_cnt_r, cfg_i.open_loop_startup_time)) begin
        locked_rotor_flag_r <= 1'b1;
      end else if (reg_wr_i && reg_addr_i == ADDR_RESET_CMD && reg_wdata_i == CMD_CLR_LATCH) begin
        locked_rotor_flag_r <= 1'b0;
      end
    end
  end

  // startup period bit: high until first back-emf
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      startup_period_bit_r <= 1'b0;
    end else if (clk_en_i) begin
      startup_period_bit_r <= startup_active_i && !bemf_seen_i;
    end
  end

  // ==========================================
  // fet short with blanking, overcurrent with mask time
  logic [7:0] blank_cnt_r;
  logic [7:0] oc_cnt_r;
  logic fet_short_flag_r;
  logic overcurrent_flag_r;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      blank_cnt_r <= 8'h00;
      fet_short_flag_r <= 1'b0;
    end else if (clk_en_i) begin
      if (!sense_i.fet_short_raw) begin
        blank_cnt_r <= 8'h00;
      end else if (tick_r && !count_done(blank_cnt_r, cfg_i.fet_short_blanking)) begin
        blank_cnt_r <= blank_cnt_r + 8'h01;
      end
      // detections inside the blanking interval are ignored
      if (sense_i.fet_short_raw && count_done(blank_cnt_r, cfg_i.fet_short_blanking)) begin
        fet_short_flag_r <= 1'b1;
      end else if (reg_wr_i && reg_addr_i == ADDR_RESET_CMD && reg_wdata_i == CMD_CLR_LATCH) begin
        fet_short_flag_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      oc_cnt_r <= 8'h00;
      overcurrent_flag_r <= 1'b0;
    end else if (clk_en_i) begin
      if (!sense_i.oc_raw) begin
        oc_cnt_r <= 8'h00;
      end else if (tick_r && oc_cnt_r != 8'hFF) begin
        oc_cnt_r <= oc_cnt_r + 8'h01;
      end
      // strictly longer than the mask time
      if (sense_i.oc_raw && oc_cnt_r > cfg_i.overcurrent_mask_time) begin
        overcurrent_flag_r <= 1'b1;
      end else if (reg_wr_i && reg_addr_i == ADDR_RESET_CMD && reg_wdata_i == CMD_CLR_LATCH) begin
        overcurrent_flag_r <= 1'b0;
      end
    end
  end

  // ==========================================
  // level flags following their comparators
  logic fet_thermal_flag_r;
  logic gate_supply_uv_flag_r;
  logic pump_low_flag_r;
  logic main_supply_ov_flag_r;
  logic main_supply_uv_flag_r;
  logic pwm_input_fault_flag_r;
  logic regulator_uv_flag_r;
  logic open_connector_flag_r;
  logic current_limit_flag_r;
  logic thermal_shutdown_flag_r;
  logic thermal_warning_flag_r;
  logic high_supply_ov_flag_r;
  logic pump_ov_flag_r;
  logic reverse_current_flag_r;
  logic nvm_blank_flag_r;
  logic loaded_regs_blank_flag_r;
  logic speed_control_error_bit_r;
  logic speed_fault_flag_r;
  logic watchdog_timeout_flag_r;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      fet_thermal_flag_r <= 1'b0;
      gate_supply_uv_flag_r <= 1'b0;
      pump_low_flag_r <= 1'b0;
      main_supply_ov_flag_r <= 1'b0;
      main_supply_uv_flag_r <= 1'b0;
      pwm_input_fault_flag_r <= 1'b0;
      regulator_uv_flag_r <= 1'b0;
      open_connector_flag_r <= 1'b0;
      current_limit_flag_r <= 1'b0;
      thermal_shutdown_flag_r <= 1'b0;
      thermal_warning_flag_r <= 1'b0;
      high_supply_ov_flag_r <= 1'b0;
      pump_ov_flag_r <= 1'b0;
      reverse_current_flag_r <= 1'b0;
    end else if (clk_en_i) begin
      fet_thermal_flag_r <= sense_i.fet_thermal;
      gate_supply_uv_flag_r <= sense_i.gate_low_uv;
      pump_low_flag_r <= sense_i.pump_low;
      main_supply_ov_flag_r <= sense_i.main_ov;
      main_supply_uv_flag_r <= sense_i.main_uv;
      pwm_input_fault_flag_r <= pwm_fault_i;
      regulator_uv_flag_r <= cfg_i.regulator_voltage_sel ? sense_i.reg_uv_3v3 : sense_i.reg_uv_5v;
      open_connector_flag_r <= sense_i.open_conn;
      current_limit_flag_r <= sense_i.cur_limit;
      thermal_shutdown_flag_r <= cfg_i.temperature_level_sel ? sense_i.temp_shut_hi : sense_i.temp_shut_lo;
      thermal_warning_flag_r <= cfg_i.temperature_level_sel ? sense_i.temp_warn_hi : sense_i.temp_warn_lo;
      high_supply_ov_flag_r <= sense_i.high_supply_ov;
      pump_ov_flag_r <= sense_i.pump_ov;
      reverse_current_flag_r <= sense_i.reverse_cur;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      nvm_blank_flag_r <= 1'b0;
      loaded_regs_blank_flag_r <= 1'b0;
      speed_control_error_bit_r <= 1'b0;
      speed_fault_flag_r <= 1'b0;
    end else if (clk_en_i) begin
      nvm_blank_flag_r <= nvm_all_zero_i;
      loaded_regs_blank_flag_r <= loaded_all_zero_i;
      speed_control_error_bit_r <= abs_diff(speed_target_i, speed_actual_i) >
                                   (speed_target_i >> SPEED_ERR_SHIFT);
      speed_fault_flag_r <= speed_fault_cond_i;
    end
  end

  // ==========================================
  // watchdog: flagged whether or not the function is enabled
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      watchdog_timeout_flag_r <= 1'b0;
    end else if (clk_en_i) begin
      if (watchdog_expired_i) begin
        watchdog_timeout_flag_r <= 1'b1;
      end else if (reg_wr_i && reg_addr_i == ADDR_RESET_CMD && reg_wdata_i == CMD_CLR_WDOG) begin
        watchdog_timeout_flag_r <= 1'b0;
      end
    end
  end

  // ==========================================
  // checksum error, set wins over the clear command
  logic checksum_error_flag_r;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      checksum_error_flag_r <= 1'b0;
    end else if (clk_en_i) begin
      if (cfg_i.device_en && cfg_i.checksum_diag_enable && cfg_i.checksum_protect_enable &&
          checksum_mismatch_i) begin
        checksum_error_flag_r <= 1'b1;
      end else if (reg_wr_i && reg_addr_i == ADDR_RESET_CMD && reg_wdata_i == CMD_CLR_CSUM) begin
        checksum_error_flag_r <= 1'b0;
      end
    end
  end

  // ==========================================
  // driver stage control
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      drive_o <= '0;
    end else if (clk_en_i) begin
      drive_o.drivers_off <= locked_rotor_flag_r || fet_short_flag_r || gate_supply_uv_flag_r ||
                             pump_low_flag_r || main_supply_ov_flag_r || main_supply_uv_flag_r ||
                             overcurrent_flag_r || thermal_shutdown_flag_r ||
                             (pwm_input_fault_flag_r && !cfg_i.pwm_fault_action_sel) ||
                             (checksum_error_flag_r && cfg_i.checksum_protect_mode) ||
                             (watchdog_timeout_flag_r && cfg_i.watchdog_en && !cfg_i.watchdog_action_sel);
      drive_o.pump_off <= main_supply_ov_flag_r;
      drive_o.emergency_duty <= (pwm_input_fault_flag_r && cfg_i.pwm_fault_action_sel) ||
                                (watchdog_timeout_flag_r && cfg_i.watchdog_en && cfg_i.watchdog_action_sel);
    end
  end

  // ==========================================
  // status window select and snapshot
  logic [3:0] status_select_r;
  logic [15:0] stat_hold_r;
  logic [23:0] status_now;

  assign status_now = status_src_i[status_select_r];

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      status_select_r <= RST_STAT_SEL;
    end else if (clk_en_i && reg_wr_i && reg_addr_i == ADDR_STAT_SEL) begin
      status_select_r <= reg_wdata_i[3:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      stat_hold_r <= RST_STAT_HOLD;
    end else if (clk_en_i && reg_rd_i && reg_addr_i == ADDR_STAT_LOW) begin
      stat_hold_r <= status_now[23:8];
    end
  end

  // ==========================================
  // read path; writes to flag and status addresses have no effect
  logic [7:0] rd_nxt;

  always_comb begin
    rd_nxt = RST_BYTE;
    if (reg_addr_i == ADDR_FLAGS_A) begin
      rd_nxt = {locked_rotor_flag_r, fet_thermal_flag_r, fet_short_flag_r, gate_supply_uv_flag_r,
                pump_low_flag_r, main_supply_ov_flag_r, main_supply_uv_flag_r, overcurrent_flag_r};
    end else if (reg_addr_i == ADDR_FLAGS_B) begin
      rd_nxt = {pwm_input_fault_flag_r, regulator_uv_flag_r, checksum_error_flag_r, open_connector_flag_r,
                current_limit_flag_r, watchdog_timeout_flag_r, thermal_shutdown_flag_r, thermal_warning_flag_r};
    end else if (reg_addr_i == ADDR_FLAGS_C) begin
      rd_nxt = {2'b00, nvm_blank_flag_r, loaded_regs_blank_flag_r, speed_fault_flag_r,
                speed_control_error_bit_r, startup_period_bit_r, high_supply_ov_flag_r};
    end else if (reg_addr_i == ADDR_FLAGS_D) begin
      rd_nxt = {6'b000000, pump_ov_flag_r, reverse_current_flag_r};
    end else if (reg_addr_i == ADDR_STAT_LOW) begin
      rd_nxt = status_now[7:0];
    end else if (reg_addr_i == ADDR_STAT_MID) begin
      rd_nxt = stat_hold_r[7:0];
    end else if (reg_addr_i == ADDR_STAT_HIGH) begin
      rd_nxt = stat_hold_r[15:8];
    end else if (reg_addr_i == ADDR_SEED) begin
      rd_nxt = cfg_i.checksum_seed_value;
    end else if (reg_addr_i == ADDR_STAT_SEL) begin
      rd_nxt = {4'h0, status_select_r};
    end
  end

  // read data stands one cycle after the strobe and only then
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= RST_BYTE;
    end else if (clk_en_i) begin
      reg_rdata_o <= reg_rd_i ? rd_nxt : RST_BYTE;
    end
  end

endmodule
`default_nettype wire

// ===== verification/diag_bank_chk.sv
// port checker for the diagnostic flag and status bank
`timescale 1ns/10ps
`default_nettype none
module diag_bank_chk
  import diag_bank_pkg::*;
#(
  parameter int SPEED_W = 16
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // register port
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // protection side
  input wire sense_type sense_i,
  input wire config_type cfg_i,
  input wire logic pwm_fault_i,
  input wire logic nvm_all_zero_i,
  input wire logic loaded_all_zero_i,
  input wire logic [SPEED_W-1:0] speed_target_i,
  input wire logic [SPEED_W-1:0] speed_actual_i,
  input wire logic [15:0][23:0] status_src_i,
  input wire drive_type drive_o
);
  // ==========================================
  // shadow select, snapshot and expected status byte
  logic [3:0] sel_r;
  logic [15:0] hold_r;
  logic [7:0] stat_r;
  logic [23:0] cur_w;
  logic [SPEED_W-1:0] diff_w;
  logic [3:0] a_w;
  logic [2:0] b_w;
  logic [2:0] c_w;
  assign cur_w = status_src_i[sel_r];
  assign diff_w = speed_target_i > speed_actual_i ? speed_target_i - speed_actual_i : speed_actual_i - speed_target_i;
  assign a_w = {sense_i.gate_low_uv, sense_i.pump_low, sense_i.main_ov, sense_i.main_uv};
  assign b_w = {cfg_i.regulator_voltage_sel ? sense_i.reg_uv_3v3 : sense_i.reg_uv_5v,
    cfg_i.temperature_level_sel ? sense_i.temp_shut_hi : sense_i.temp_shut_lo,
    cfg_i.temperature_level_sel ? sense_i.temp_warn_hi : sense_i.temp_warn_lo};
  assign c_w = {nvm_all_zero_i, loaded_all_zero_i, diff_w > (speed_target_i >> SPEED_ERR_SHIFT)};
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sel_r <= RST_STAT_SEL;
    end else if (reg_wr_i && reg_addr_i == ADDR_STAT_SEL) begin
      sel_r <= reg_wdata_i[3:0];
    end
  end
  // snapshot moves only on a low byte read, so a select change waits for it
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      hold_r <= RST_STAT_HOLD;
    end else if (reg_rd_i && reg_addr_i == ADDR_STAT_LOW) begin
      hold_r <= cur_w[23:8];
    end
  end
  always_ff @(posedge core_clk_i) begin
    stat_r <= (reg_addr_i == ADDR_STAT_LOW) ? cur_w[7:0] : (reg_addr_i == ADDR_STAT_MID) ? hold_r[7:0] : hold_r[15:8];
  end
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);
  // ==========================================
  // driver stage
  chk_ov_pump_off:
    assert property (sense_i.main_ov [*2] |=> drive_o.pump_off && drive_o.drivers_off)
    else $error("supply overvoltage left driver or pump on");
  chk_uv_drv_off:
    assert property ((sense_i.gate_low_uv || sense_i.pump_low || sense_i.main_uv) [*2] |=> drive_o.drivers_off)
    else $error("undervoltage left drivers on");
  chk_pwm_action:
    assert property ((pwm_fault_i && $stable(cfg_i)) [*2] |=>
      ($past(cfg_i.pwm_fault_action_sel) ? drive_o.emergency_duty : drive_o.drivers_off))
    else $error("pwm fault action wrong");
  // ==========================================
  // flag and status reads
  chk_flags_a_read:
    assert property (reg_rd_i && reg_addr_i == ADDR_FLAGS_A && !$past(reset_i) && $stable(a_w)
      |=> reg_rdata_o[4:1] == $past(a_w)) else $error("supply flags read wrong");
  chk_flags_b_read:
    assert property (reg_rd_i && reg_addr_i == ADDR_FLAGS_B && !$past(reset_i) && $stable(b_w)
      |=> {reg_rdata_o[6], reg_rdata_o[1:0]} == $past(b_w)) else $error("selected level flags read wrong");
  chk_flags_c_read:
    assert property (reg_rd_i && reg_addr_i == ADDR_FLAGS_C && !$past(reset_i) && $stable(c_w)
      |=> {reg_rdata_o[5:4], reg_rdata_o[2]} == $past(c_w)) else $error("blank or speed bits read wrong");
  chk_stat_low:
    assert property (reg_rd_i && reg_addr_i == ADDR_STAT_LOW |=> reg_rdata_o == stat_r)
    else $error("status low byte wrong");
  chk_stat_hold:
    assert property (reg_rd_i && (reg_addr_i == ADDR_STAT_MID || reg_addr_i == ADDR_STAT_HIGH)
      |=> reg_rdata_o == stat_r) else $error("status snapshot byte wrong");
  cover property (reg_rd_i && reg_addr_i == ADDR_STAT_LOW);
  cover property (drive_o.emergency_duty);
  cover property (drive_o.pump_off);
endmodule
bind motor_fault_diag_status_bank diag_bank_chk #(.SPEED_W(SPEED_W)) chk_inst (.core_clk_i, .reset_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sense_i, .cfg_i, .pwm_fault_i,
  .nvm_all_zero_i, .loaded_all_zero_i, .speed_target_i, .speed_actual_i, .status_src_i, .drive_o);
`default_nettype wire

// ===== verification/diag_host_model.sv
// host controller model speaking the register port
`timescale 1ns/10ps
`default_nettype none
module diag_host_model
  import diag_bank_pkg::*;
(
  // clock
  input wire logic clk_i,
  // register port
  output logic [11:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [7:0] rdata_i
);
  initial begin
    {addr_o, wdata_o, wr_o, rd_o} = '0;
  end
  // ==========================================
  // one strobe cycle each; called just after a rising edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
    @(posedge clk_i);
  endtask
  // data taken at the edge closing the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(posedge clk_i);
    d = rdata_i;
  endtask
  task automatic clr_checksum();
    wr(ADDR_RESET_CMD, CMD_CLR_CSUM);
  endtask
endmodule
`default_nettype wire

// ===== verification/motor_fault_diag_status_bank_bench.sv
// self-checking bench for the diagnostic flag and status bank
`timescale 1ns/10ps
`default_nettype none
module motor_fault_diag_status_bank_bench
  import diag_bank_pkg::*;
;
  `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
  // ==========================================
  // stimulus and wires
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  int seed = 56;
  logic clk, rst, bemf, start, pwm, wdog, csm, nvm, ldz, sfc, wr, rd;
  logic [15:0] tgt, act;
  logic [15:0][23:0] src;
  logic [11:0] addr;
  logic [7:0] wdata, rdata;
  logic [31:0] r, q, e;
  logic [23:0] h;
  logic [31:0] spd_tab [3] = '{32'h0100_0110, 32'h0100_0111, 32'h0100_00EF};
  sense_type sense, s;
  config_type cfg, c;
  drive_type drv;
  motor_fault_diag_status_bank #(.SPEED_W(16)) motor_fault_diag_status_bank_inst (.core_clk_i(clk), .reset_i(rst),
    .clk_en_i(1'b1), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .sense_i(sense), .cfg_i(cfg), .bemf_seen_i(bemf), .startup_active_i(start), .pwm_fault_i(pwm),
    .watchdog_expired_i(wdog), .checksum_mismatch_i(csm), .nvm_all_zero_i(nvm), .loaded_all_zero_i(ldz),
    .speed_target_i(tgt), .speed_actual_i(act), .speed_fault_cond_i(sfc), .status_src_i(src), .drive_o(drv));
  diag_host_model host_inst (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata));
  task automatic rchk(input logic [11:0] a, input logic [7:0] m, input logic [7:0] x);
    logic [7:0] d;
    host_inst.rd(a, d);
    `CHK(d & m, x & m)
  endtask
  function automatic logic [31:0] expect_flags();
    logic [15:0] df;
    df = (tgt > act) ? tgt - act : act - tgt;
    return {6'h00, sense.pump_ov, sense.reverse_cur, 2'b00, nvm, ldz, sfc, df > (tgt >> SPEED_ERR_SHIFT), 1'b0,
      sense.high_supply_ov, pwm, cfg.regulator_voltage_sel ? sense.reg_uv_3v3 : sense.reg_uv_5v, 1'b0,
      sense.open_conn, sense.cur_limit, 1'b0, cfg.temperature_level_sel ? sense.temp_shut_hi : sense.temp_shut_lo,
      cfg.temperature_level_sel ? sense.temp_warn_hi : sense.temp_warn_lo, 1'b0, sense.fet_thermal, 1'b0,
      sense.gate_low_uv, sense.pump_low, sense.main_ov, sense.main_uv, 1'b0};
  endfunction
  task automatic conclude();
    $display("cmp_count=%0d fails=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========================================
  // clock and hang limit
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    rst = 1'b1;
    {sense, cfg} = '0;
    {bemf, start, pwm, wdog, csm, nvm, ldz, sfc, tgt, act} = '0;
    cfg.checksum_seed_value = 8'hA5;
    src = '0;
    cfg.open_loop_startup_time = 8'h03;
    cfg.fet_short_blanking = 8'h04;
    cfg.overcurrent_mask_time = 8'h02;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk(ADDR_STAT_MID, 8'hFF, 8'h00);
    rchk(ADDR_STAT_HIGH, 8'hFF, 8'h00);
    rchk(12'h3FF, 8'hFF, 8'h00);
    for (int i = 0; i < 8; i++) begin
      host_inst.wr(ADDR_FLAGS_A + 12'(i), 8'hFF);
      rchk(ADDR_FLAGS_A + 12'(i), 8'hFF, (i == 7) ? 8'hA5 : 8'h00);
    end
    // corner selects then random ones; select moves after the snapshot
    for (int i = 0; i < 6; i++) begin
      r = (i == 0) ? 32'h0 : (i == 1) ? 32'hF : $random(seed);
      for (int j = 0; j < 16; j++) src[j] <= 24'($random(seed));
      host_inst.wr(ADDR_STAT_SEL, {4'h0, r[3:0]});
      h = src[r[3:0]];
      rchk(ADDR_STAT_LOW, 8'hFF, h[7:0]);
      for (int j = 0; j < 16; j++) src[j] <= ~src[j];
      host_inst.wr(ADDR_STAT_SEL, {4'h0, ~r[3:0]});
      rchk(ADDR_STAT_MID, 8'hFF, h[15:8]);
      rchk(ADDR_STAT_HIGH, 8'hFF, h[23:16]);
    end
    // watchdog disabled, then drivers off, then emergency
    for (int k = 0; k < 3; k++) begin
      cfg.watchdog_en <= (k != 0);
      cfg.watchdog_action_sel <= (k == 2);
      wdog <= 1'b1;
      @(posedge clk);
      wdog <= 1'b0;
      repeat (3) @(posedge clk);
      rchk(ADDR_FLAGS_B, 8'h04, 8'h04);
      `CHK({drv.drivers_off, drv.emergency_duty}, {k == 1, k == 2})
      host_inst.wr(ADDR_RESET_CMD, CMD_CLR_WDOG);
      rchk(ADDR_FLAGS_B, 8'h04, 8'h00);
    end
    cfg.watchdog_en <= 1'b0;
    cfg.checksum_protect_enable <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      cfg.device_en <= (k != 0);
      cfg.checksum_diag_enable <= (k >= 2);
      cfg.checksum_protect_mode <= (k == 2);
      csm <= 1'b1;
      @(posedge clk);
      csm <= 1'b0;
      repeat (3) @(posedge clk);
      rchk(ADDR_FLAGS_B, 8'h20, (k >= 2) ? 8'h20 : 8'h00);
      `CHK(drv.drivers_off, k == 2)
      host_inst.clr_checksum();
      rchk(ADDR_FLAGS_B, 8'h20, 8'h00);
      `CHK(drv.drivers_off, 1'b0)
    end
    start <= 1'b1;
    repeat (2) @(posedge clk);
    rchk(ADDR_FLAGS_C, 8'h02, 8'h02);
    rchk(ADDR_FLAGS_A, 8'h80, 8'h00);
    repeat (100) @(posedge clk);
    rchk(ADDR_FLAGS_A, 8'h80, 8'h80);
    `CHK(drv.drivers_off, 1'b1)
    bemf <= 1'b1;
    repeat (2) @(posedge clk);
    rchk(ADDR_FLAGS_C, 8'h02, 8'h00);
    start <= 1'b0;
    host_inst.wr(ADDR_RESET_CMD, CMD_CLR_LATCH);
    rchk(ADDR_FLAGS_A, 8'h80, 8'h00);
    // short bursts sit inside the mask or blanking time, long ones outlast it
    for (int k = 0; k < 4; k++) begin
      s = '0;
      s.oc_raw = !k[1];
      s.fet_short_raw = k[1];
      sense <= s;
      repeat (k[0] ? 200 : 20) @(posedge clk);
      sense <= '0;
      repeat (3) @(posedge clk);
      rchk(ADDR_FLAGS_A, 8'h21, {2'b00, k[1] & k[0], 4'h0, !k[1] & k[0]});
      if (k < 2) `CHK(drv.drivers_off, k[0])
      host_inst.wr(ADDR_RESET_CMD, CMD_CLR_LATCH);
    end
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      q = $random(seed);
      s = sense_type'(q[17:0]);
      s.fet_short_raw = 1'b0;
      s.oc_raw = 1'b0;
      c = cfg;
      c.regulator_voltage_sel = r[0];
      c.temperature_level_sel = r[1];
      c.pwm_fault_action_sel = r[2];
      sense <= s;
      cfg <= c;
      {pwm, nvm, ldz, sfc} <= r[6:3];
      {tgt, act} <= (i < 3) ? spd_tab[i] : $random(seed);
      repeat (3) @(posedge clk);
      e = expect_flags();
      for (int j = 0; j < 4; j++) begin
        rchk(ADDR_FLAGS_A + 12'(j), 8'hFF, e[8*j +: 8]);
      end
      `CHK(drv.pump_off, s.main_ov)
      `CHK(drv.drivers_off, |{e[4:1], e[9], pwm & !c.pwm_fault_action_sel})
      `CHK(drv.emergency_duty, pwm & c.pwm_fault_action_sel)
    end
    conclude();
  end
endmodule
`default_nettype wire
